// *** verilog/stxe_pkg.sv ***
// constants and types for the skip, table-read and xor execute unit
// ----------------------------------------------------------------
// Function
// - nibble swap loads accumulator with data byte halves exchanged, memory untouched
// - skip when zero skips next instruction if byte is zero: 2 cycles, else 1
// - any met skip discards the prefetched instruction and inserts one dummy cycle
// - copy test skip loads byte into accumulator and skips if byte is zero
// - bit test skip skips next instruction, in 2 cycles, when selected bit is zero
// - current page table read: low byte to memory, high part to table high latch
// - last page table read does the same from the last program page
// - xor with memory writes accumulator and updates only the zero flag
// - exclusive or to memory writes data memory and updates only the zero flag
// - xor immediate writes accumulator and updates only the zero flag
// ----------------------------------------------------------------
`default_nettype none

package stxe_pkg;

	localparam int DATA_W = 8;
	localparam int ROM_W  = 14;
	localparam int HIGH_W = ROM_W - DATA_W;
	localparam int PAGE_W = 3;
	localparam int ADDR_W = PAGE_W + DATA_W;

	localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
	localparam logic              ZERO_RST  = 1'b0;
	localparam logic [HIGH_W-1:0] HIGH_RST  = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 11'h000;
	localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;

	// instructions executed by this unit
	typedef enum logic [3:0] {
		OP_NOP      = 4'h0,
		OP_SWAP_ACC = 4'h1,
		OP_SKIP_Z   = 4'h2,
		OP_COPY_SKP = 4'h3,
		OP_SKIP_BIT = 4'h4,
		OP_TAB_CUR  = 4'h5,
		OP_TAB_LAST = 4'h6,
		OP_XOR_ACC  = 4'h7,
		OP_XOR_MEM  = 4'h8,
		OP_XOR_IMM  = 4'h9
	} stxe_op_t;

	// one instruction as presented by the decoder
	typedef struct packed {
		stxe_op_t          op;
		logic [2:0]        bitSel;
		logic [DATA_W-1:0] imm;
		logic [DATA_W-1:0] memData;
	} stxe_cmd_t;

	// execution states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DUMMY = 3'b010,
		ST_TABLE = 3'b100
	} stxe_state_t;

endpackage : stxe_pkg

`default_nettype wire

// *** verilog/stxe_core.sv ***
// execute unit for swap, skip, table read and xor instructions
`timescale 1ns/1ps
`default_nettype none

module stxe_core (
	// clock and reset
	input  wire logic                            clk_sys,
	input  wire logic                            rstn,
	// instruction from the decoder
	input  wire logic                            exStart,
	input  wire stxe_pkg::stxe_cmd_t             cmd,
	input  wire logic [stxe_pkg::PAGE_W-1:0]     pcPage,
	input  wire logic [stxe_pkg::DATA_W-1:0]     tablePointer,
	// program memory table port
	output logic                                 romRd,
	output logic [stxe_pkg::ADDR_W-1:0]          romAddr,
	input  wire logic [stxe_pkg::ROM_W-1:0]      romData,
	// data memory write port
	output logic                                 memWr,
	output logic [stxe_pkg::DATA_W-1:0]          memWrData,
	// core state
	output logic [stxe_pkg::DATA_W-1:0]          acc,
	output logic                                 zeroFlag,
	output logic [stxe_pkg::HIGH_W-1:0]          tableHighLatch,
	// sequencing
	output logic                                 busy,
	output logic                                 discardFetch,
	output logic                                 done
);

	stxe_pkg::stxe_state_t            state_q, state_d;
	logic [stxe_pkg::DATA_W-1:0]      acc_q, acc_d;
	logic                             zero_q, zero_d;
	logic [stxe_pkg::HIGH_W-1:0]      high_q, high_d;
	logic [stxe_pkg::ADDR_W-1:0]      addr_q, addr_d;
	logic                             romRd_q, romRd_d;
	logic                             memWr_q, memWr_d;
	logic [stxe_pkg::DATA_W-1:0]      wrData_q, wrData_d;
	logic                             done_q, done_d;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire idle     = (state_q == stxe_pkg::ST_IDLE);
	wire go       = exStart & idle;
	wire opSwap   = (cmd.op == stxe_pkg::OP_SWAP_ACC);
	wire opSkipZ  = (cmd.op == stxe_pkg::OP_SKIP_Z);
	wire opCopy   = (cmd.op == stxe_pkg::OP_COPY_SKP);
	wire opBit    = (cmd.op == stxe_pkg::OP_SKIP_BIT);
	wire opTabCur = (cmd.op == stxe_pkg::OP_TAB_CUR);
	wire opTabLst = (cmd.op == stxe_pkg::OP_TAB_LAST);
	wire opXorA   = (cmd.op == stxe_pkg::OP_XOR_ACC);
	wire opXorM   = (cmd.op == stxe_pkg::OP_XOR_MEM);
	wire opXorI   = (cmd.op == stxe_pkg::OP_XOR_IMM);
	wire opTable  = opTabCur | opTabLst;
	wire opXor    = opXorA | opXorM | opXorI;

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	wire memZero = (cmd.memData == 8'h00);
	wire bitZero = ~cmd.memData[cmd.bitSel];
	wire [7:0] swapped = {cmd.memData[3:0], cmd.memData[7:4]};
	wire [7:0] xorMem  = acc_q ^ cmd.memData;
	wire [7:0] xorImm  = acc_q ^ cmd.imm;
	wire [7:0] xorRes  = opXorI ? xorImm : xorMem;

	// skip decision for the three skip forms
	wire skipHit = ((opSkipZ | opCopy) & memZero)
		| (opBit & bitZero);

	// page is the current one or the last one
	wire [2:0] tabPage = opTabLst ? stxe_pkg::LAST_PAGE : pcPage;

	// accumulator next value
	assign acc_d = !go   ? acc_q
		: opSwap ? swapped
		: opCopy ? cmd.memData
		: (opXorA | opXorI) ? xorRes
		: acc_q;

	// zero flag follows only the xor result
	assign zero_d = (go & opXor) ? (xorRes == 8'h00) : zero_q;

	// memory write: xor to memory now, table low byte on capture
	assign memWr_d  = (go & opXorM) | (state_q == stxe_pkg::ST_TABLE);
	assign wrData_d = (state_q == stxe_pkg::ST_TABLE)
		? romData[7:0]
		: xorMem;

	// table high latch loads on capture only
	assign high_d = (state_q == stxe_pkg::ST_TABLE)
		? romData[13:8] : high_q;

	assign addr_d  = (go & opTable) ? {tabPage, tablePointer} : addr_q;
	assign romRd_d = go & opTable;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		done_d  = 1'b0;
		case (state_q)
			stxe_pkg::ST_IDLE: begin
				if (go & skipHit) begin
					state_d = stxe_pkg::ST_DUMMY;
				end else if (go & opTable) begin
					state_d = stxe_pkg::ST_TABLE;
				end else if (go) begin
					done_d = 1'b1;
				end
			end
			stxe_pkg::ST_DUMMY: begin
				state_d = stxe_pkg::ST_IDLE;
				done_d  = 1'b1;
			end
			stxe_pkg::ST_TABLE: begin
				state_d = stxe_pkg::ST_IDLE;
				done_d  = 1'b1;
			end
			default: begin
				state_d = stxe_pkg::ST_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q  <= stxe_pkg::ST_IDLE;
			acc_q    <= stxe_pkg::ACC_RST;
			zero_q   <= stxe_pkg::ZERO_RST;
			high_q   <= stxe_pkg::HIGH_RST;
			addr_q   <= stxe_pkg::ADDR_RST;
			romRd_q  <= 1'b0;
			memWr_q  <= 1'b0;
			wrData_q <= stxe_pkg::ACC_RST;
			done_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			acc_q    <= acc_d;
			zero_q   <= zero_d;
			high_q   <= high_d;
			addr_q   <= addr_d;
			romRd_q  <= romRd_d;
			memWr_q  <= memWr_d;
			wrData_q <= wrData_d;
			done_q   <= done_d;
		end
	end

	// outputs
	assign busy           = ~idle;
	assign discardFetch   = (state_q == stxe_pkg::ST_DUMMY);
	assign done           = done_q;
	assign romRd          = romRd_q;
	assign romAddr        = addr_q;
	assign memWr          = memWr_q;
	assign memWrData      = wrData_q;
	assign acc            = acc_q;
	assign zeroFlag       = zero_q;
	assign tableHighLatch = high_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_swap;
		@(posedge clk_sys) disable iff (!rstn)
		go && opSwap |=> acc == {$past(cmd.memData[3:0]),
			$past(cmd.memData[7:4])} && !memWr && done;
	endproperty
	a_swap: assert property (p_swap)
		else $error("swap result wrong");

	// zero byte: two cycles with done last, otherwise done at once
	property p_skipz;
		@(posedge clk_sys) disable iff (!rstn)
		go && opSkipZ |=> if ($past(cmd.memData) == 8'h00) (!done ##1 done)
			else done;
	endproperty
	a_skipz: assert property (p_skipz)
		else $error("skip when zero timing wrong");

	property p_dummy;
		@(posedge clk_sys) disable iff (!rstn)
		go && skipHit |=> discardFetch && busy ##1 !discardFetch && done;
	endproperty
	a_dummy: assert property (p_dummy)
		else $error("dummy cycle missing");

	property p_copy;
		@(posedge clk_sys) disable iff (!rstn)
		go && opCopy |=> acc == $past(cmd.memData)
			&& discardFetch == ($past(cmd.memData) == 8'h00);
	endproperty
	a_copy: assert property (p_copy)
		else $error("copy test skip wrong");

	property p_bit;
		@(posedge clk_sys) disable iff (!rstn)
		go && opBit && bitZero |=> discardFetch ##1 done;
	endproperty
	a_bit: assert property (p_bit)
		else $error("bit skip wrong");

	property p_tabcur;
		@(posedge clk_sys) disable iff (!rstn)
		go && opTabCur |=> romRd && romAddr == {$past(pcPage),
			$past(tablePointer)} ##1 memWr && done
			&& memWrData == $past(romData[7:0])
			&& tableHighLatch == $past(romData[13:8]);
	endproperty
	a_tabcur: assert property (p_tabcur)
		else $error("current page table read wrong");

	property p_tablast;
		@(posedge clk_sys) disable iff (!rstn)
		go && opTabLst |=> romRd && romAddr[10:8] == 3'h7
			&& romAddr[7:0] == $past(tablePointer) ##1 memWr;
	endproperty
	a_tablast: assert property (p_tablast)
		else $error("last page table read wrong");

	property p_xora;
		@(posedge clk_sys) disable iff (!rstn)
		go && opXorA |=> acc == ($past(acc) ^ $past(cmd.memData))
			&& zeroFlag == (acc == 8'h00) && !memWr;
	endproperty
	a_xora: assert property (p_xora)
		else $error("xor with memory wrong");

	property p_xor_to_mem;
		@(posedge clk_sys) disable iff (!rstn)
		go && opXorM |=> memWr && acc == $past(acc)
			&& memWrData == ($past(acc) ^ $past(cmd.memData))
			&& zeroFlag == (memWrData == 8'h00);
	endproperty
	a_xor_to_mem: assert property (p_xor_to_mem)
		else $error("xor to memory wrong");

	property p_xori;
		@(posedge clk_sys) disable iff (!rstn)
		go && opXorI |=> acc == ($past(acc) ^ $past(cmd.imm))
			&& zeroFlag == (acc == 8'h00);
	endproperty
	a_xori: assert property (p_xori)
		else $error("xor immediate wrong");

	property p_flags;
		@(posedge clk_sys) disable iff (!rstn)
		go && !opXor |=> $stable(zeroFlag)
			##1 ($stable(zeroFlag) || $past(go && opXor));
	endproperty
	a_flags: assert property (p_flags)
		else $error("flag changed by non xor");

	c_skip:  cover property (@(posedge clk_sys) disable iff (!rstn)
		go && opSkipZ && memZero);
	c_table: cover property (@(posedge clk_sys) disable iff (!rstn)
		go && opTabLst ##2 done);
	c_xorz:  cover property (@(posedge clk_sys) disable iff (!rstn)
		go && opXorM ##1 zeroFlag);

endmodule : stxe_core

`default_nettype wire

// *** verif/skip_table_xor_execute_bench.sv ***
// self-checking bench for the skip, table-read and xor execute unit
`timescale 1ns/1ps
`default_nettype none

module skip_table_xor_execute_bench;

	// ----------------------------------------------------------------
	// signals and model state
	// ----------------------------------------------------------------
	logic                        clk_sys      = 1'b0;
	logic                        rstn         = 1'b0;
	logic                        exStart      = 1'b0;
	stxe_pkg::stxe_cmd_t         cmd          = '0;
	logic [stxe_pkg::PAGE_W-1:0] pcPage       = '0;
	logic [stxe_pkg::DATA_W-1:0] tablePointer = '0;
	logic [stxe_pkg::ROM_W-1:0]  romData      = '0;
	logic                        romRd;
	logic [stxe_pkg::ADDR_W-1:0] romAddr;
	logic                        memWr;
	logic [stxe_pkg::DATA_W-1:0] memWrData;
	logic [stxe_pkg::DATA_W-1:0] acc;
	logic                        zeroFlag;
	logic [stxe_pkg::HIGH_W-1:0] tableHighLatch;
	logic                        busy;
	logic                        discardFetch;
	logic                        done;
	int                          miscompares  = 0;
	int                          checks       = 0;
	int                          mAcc;
	int                          mZero;
	int                          mHigh;

	// unit under test
	stxe_core uut (.clk_sys(clk_sys), .rstn(rstn), .exStart(exStart),
		.cmd(cmd), .pcPage(pcPage), .tablePointer(tablePointer),
		.romRd(romRd), .romAddr(romAddr), .romData(romData), .memWr(memWr),
		.memWrData(memWrData), .acc(acc), .zeroFlag(zeroFlag),
		.tableHighLatch(tableHighLatch), .busy(busy),
		.discardFetch(discardFetch), .done(done));

	// 10 MHz system clock
	always #50 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input int exp);
		checks++;
		if (seen !== 16'(exp)) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, 16'(exp), seen);
		end
	endtask : chk

	task report_and_stop;
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// one instruction: drive, predict, compare every cycle of it
	task automatic exec(input int op, input int mem, input int imm,
		input int bs, input int word);
		int skip;
		int wr;
		int wdat;
		int addr;
		int tab;
		skip = 0; wr = 0; wdat = 0; tab = 0; addr = 0;
		@(negedge clk_sys);
		cmd.op = stxe_pkg::stxe_op_t'(op[3:0]);
		cmd.bitSel = bs[2:0];
		cmd.imm = imm[7:0];
		cmd.memData = mem[7:0];
		pcPage = 3'($urandom);
		tablePointer = 8'($urandom);
		romData = 14'($urandom); // the word only stands in the fetch cycle
		exStart = 1'b1;
		case (op)
			1: mAcc = {mem[3:0], mem[7:4]};
			2: skip = (mem == 0);
			3: begin
				mAcc = mem;
				skip = (mem == 0);
			end
			4: skip = (mem[bs] == 1'b0);
			5, 6: begin
				tab = 1; wr = 1; wdat = word & 'hff; mHigh = word >> 8;
				addr = {(op == 6) ? stxe_pkg::LAST_PAGE : pcPage, tablePointer};
			end
			7: begin
				mAcc = mAcc ^ mem;
				mZero = (mAcc == 0);
			end
			8: begin
				wr = 1; wdat = mAcc ^ mem;
				mZero = (wdat == 0);
			end
			9: begin
				mAcc = mAcc ^ imm;
				mZero = (mAcc == 0);
			end
			default: ;
		endcase
		@(negedge clk_sys);
		// a request while busy must be ignored
		exStart = (skip || tab);
		cmd.op = stxe_pkg::OP_XOR_IMM;
		cmd.imm = 8'hff;
		if (tab) romData = word[13:0];
		chk("done", done, !(skip || tab));
		chk("discardFetch", discardFetch, skip);
		chk("busy", busy, skip || tab);
		chk("romRd", romRd, tab);
		if (tab) chk("romAddr", romAddr, addr);
		chk("memWr", memWr, wr && !tab);
		if (wr && !tab) chk("memWrData", memWrData, wdat);
		if (skip || tab) begin
			@(negedge clk_sys);
			exStart = 1'b0;
			chk("doneLate", done, 1);
			chk("busyLate", busy, 0);
			chk("romRdLate", romRd, 0);
			chk("memWrLate", memWr, tab);
			if (tab) chk("memWrDataLate", memWrData, wdat);
		end
		chk("acc", acc, mAcc);
		chk("zeroFlag", zeroFlag, mZero);
		chk("tableHighLatch", tableHighLatch, mHigh);
	endtask : exec

	// random instruction mix, zero bytes and zero results made frequent
	task automatic rnd_exec(input int n);
		repeat (n)
			exec($urandom % 10, ($urandom % 4 == 0) ? 0 : $urandom % 256,
				($urandom % 3 == 0) ? mAcc : $urandom % 256, $urandom % 8,
				$urandom % 16384);
	endtask : rnd_exec

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(526));
		mAcc = 0; mZero = 0; mHigh = 0;
		repeat (5) @(negedge clk_sys);
		chk("accReset", acc, 0);
		rstn = 1'b1;
		// every op: byte equal to acc, then selected bit clear in a nonzero byte
		for (int op = 0; op < 10; op++) begin
			exec(op, mAcc, mAcc, op % 8, 14'h15a3);
			exec(op, 255 ^ (1 << (op % 8)), 8'h81, op % 8, 14'h2c3e);
		end
		// back to back: swap, then xor immediate taken on the very next edge
		@(negedge clk_sys);
		cmd.op = stxe_pkg::OP_SWAP_ACC;
		cmd.memData = 8'($urandom);
		exStart = 1'b1;
		@(negedge clk_sys);
		mAcc = {cmd.memData[3:0], cmd.memData[7:4]};
		chk("b2bSwapDone", done, 1);
		chk("b2bSwapAcc", acc, mAcc);
		chk("b2bSwapZero", zeroFlag, mZero);
		cmd.op = stxe_pkg::OP_XOR_IMM;
		cmd.imm = 8'($urandom);
		mAcc = mAcc ^ cmd.imm;
		mZero = (mAcc == 0);
		@(negedge clk_sys);
		exStart = 1'b0;
		chk("b2bXorDone", done, 1);
		chk("b2bXorAcc", acc, mAcc);
		chk("b2bXorZero", zeroFlag, mZero);
		rnd_exec(300);
		// reset in mid-run
		@(negedge clk_sys);
		rstn = 1'b0;
		@(negedge clk_sys);
		chk("accReset2", acc, 0);
		chk("highReset2", tableHighLatch, 0);
		chk("zeroReset2", zeroFlag, 0);
		rstn = 1'b1;
		mAcc = 0; mZero = 0; mHigh = 0;
		rnd_exec(100);
		report_and_stop();
	end

	// watchdog well beyond the expected run length
	initial begin
		#500000;
		miscompares++;
		report_and_stop();
	end

endmodule : skip_table_xor_execute_bench

`default_nettype wire
